/* File: rtl/adcsc_pkg.sv */
// Package for the converter sample and conversion control block.
// Assumes a 32-bit AHB-Lite register bus and one system clock.
package adcsc_pkg;
  localparam logic [31:0] ADCSC_CTRL_ADDR = 32'h0000_0000;
  localparam logic [31:0] ADCSC_SCAN_ADDR = 32'h0000_0004;
  localparam logic [31:0] ADCSC_TIME_ADDR = 32'h0000_0008;
  localparam logic [31:0] ADCSC_OPA_ADDR = 32'h0000_000C;
  localparam int ADCSC_ADDR_MSB = 3;
  localparam int ADCSC_ADDR_LSB = 2;
  localparam int ADCSC_POS_DONE = 0;
  localparam int ADCSC_POS_SAMPLE_CONTROL = 1;
  localparam int ADCSC_POS_AUTO_SAMPLE = 2;
  localparam int ADCSC_POS_SIM = 3;
  localparam int ADCSC_POS_GRP = 4;
  localparam int ADCSC_POS_SEL_LO = 5;
  localparam int ADCSC_POS_SEL_HI = 7;
  localparam int ADCSC_POS_CHPS_LO = 8;
  localparam int ADCSC_POS_CHPS_HI = 9;
  localparam int ADCSC_POS_B12 = 10;
  localparam logic [2:0] ADCSC_SEL_0 = 3'h0;
  localparam logic [2:0] ADCSC_SEL_1 = 3'h1;
  localparam logic [2:0] ADCSC_SEL_2 = 3'h2;
  localparam logic [2:0] ADCSC_SEL_3 = 3'h3;
  localparam logic [2:0] ADCSC_SEL_4 = 3'h4;
  localparam logic [2:0] ADCSC_SEL_6 = 3'h6;
  localparam logic [2:0] ADCSC_SEL_7 = 3'h7;
  localparam logic [1:0] ADCSC_CHPS_ONE = 2'h0;
  localparam logic [1:0] ADCSC_CHPS_TWO = 2'h1;
  localparam logic [7:0] ADCSC_SAMPLE_CONTROL_TIME_RST = 8'h03;
  localparam logic [7:0] ADCSC_CONV_TIME = 8'h0E;
  localparam logic [1:0] ADCSC_SCAN_PINS = 2'h1;
  localparam logic [1:0] ADCSC_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] ADCSC_HSIZE_WORD = 3'h2;
  typedef enum logic [1:0] {
    ADCSC_IDLE = 2'b00,
    ADCSC_SAMPLE = 2'b01,
    ADCSC_CONVERT = 2'b11
  } adcsc_state_t;
  typedef struct packed {
    logic [2:0] sel;
    logic grp;
    logic sim;
    logic auto_sample;
    logic sample_control;
    logic done;
    logic [1:0] chps;
    logic b12;
  } adcsc_ctrl_t;
  typedef struct packed {
    logic pwm1;
    logic pwm2;
    logic pwm3;
    logic pwm_sev;
    logic tmr3;
    logic tmr5;
    logic charge_time_unit;
    logic ext0;
  } adcsc_trig_t;
  typedef struct packed {
    logic sample;
    logic start;
    logic [3:0] ch_mask;
    logic sim_en;
    logic [1:0] scan_sel;
    logic [1:0] use_opamp;
    logic [1:0] use_low_reference_voltage;
  } adcsc_analog_t;
endpackage

/* File: rtl/adcsc_sync.sv */
// Trigger synchroniser with rising-edge detect per trigger line.
// Assumes trigger inputs may be asynchronous to hclk.
`timescale 1ns/1ns
module adcsc_sync
  import adcsc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire adcsc_trig_t trig_in,
  output adcsc_trig_t trig_rise
);
  typedef struct packed {
    adcsc_trig_t s1;
    adcsc_trig_t s2;
    adcsc_trig_t s3;
    adcsc_trig_t rise;
  } adcsc_sync_st_t;
  adcsc_sync_st_t st_q;
  adcsc_sync_st_t st_d;
  always_comb begin
    st_d = st_q;
    st_d.s1 = trig_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.rise = st_q.s2 & ~st_q.s3; // [RULE_23]
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign trig_rise = st_q.rise;
endmodule

/* File: rtl/adcsc_top.sv */
// Sample and conversion control for the converter, with AHB-Lite registers.
// Assumes a single-slave AHB-Lite bus on hclk and an analog core
// that follows the sample and start outputs.
`timescale 1ns/1ns
// Operation
// [RULE_01] Group 1: codes 0-2 pick PWM generators 1-3 trigger; others reserved.
// [RULE_02] Group 0 code 7: internal counter ends sampling (auto-convert).
// [RULE_03] Group 0 code 6: charge-time unit event ends sampling.
// [RULE_04] Group 0 code 4 uses timer 5, code 2 timer 3 compare.
// [RULE_05] Group 0 code 3: PWM special event trigger ends sampling.
// [RULE_06] Group 0 code 1: external interrupt pin 0 edge ends sampling.
// [RULE_07] Manual mode: software writing sample control 0 starts conversion.
// [RULE_08] Non-manual modes: hardware clears sample control on trigger.
// [RULE_09] Simultaneous sample only acts for channel count 01 or 1x.
// [RULE_10] Simultaneous: four channels for 1x, two channels for 01.
// [RULE_11] Without simultaneous: channels sampled one after another.
// [RULE_12] In twelve-bit mode simultaneous bit reads zero.
// [RULE_13] Auto-sample sets sample control after conversion; else software sets it.
// [RULE_14] Sample control 1 means sampling, 0 means holding.
// [RULE_15] Done set at conversion end; zero before and during conversion.
// [RULE_16] Software clears done by writing 0; writing 1 is not allowed.
// [RULE_17] Clearing done does not disturb running sampling or conversion.
// [RULE_18] Done cleared by hardware when a new conversion starts.
// [RULE_19] Software should not clear done while auto-sample is set.
// [RULE_20] Scan bits 1 and 0 include or skip their inputs.
// [RULE_21] Op amp enable routes op amp output instead of the pin.
// [RULE_22] Scan bits all writable; missing pins convert low reference.
// [RULE_23] Hardware triggers are synchronised and edge detected, one per event.
module adcsc_top
  import adcsc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire adcsc_trig_t trig_in,
  output adcsc_analog_t analog_out
);
  typedef struct packed {
    adcsc_ctrl_t ctrl;
    logic [1:0] scan;
    logic [1:0] opa;
    logic [7:0] sample_control_time;
    adcsc_state_t state;
    logic [7:0] cnt;
    logic [1:0] seq;
    logic wr_pend;
    logic [1:0] wr_idx;
    logic [31:0] rdata;
    adcsc_analog_t ana;
  } adcsc_st_t;
  adcsc_st_t st_q;
  adcsc_st_t st_d;
  adcsc_trig_t trig_rise;
  adcsc_sync u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .trig_in(trig_in),
    .trig_rise(trig_rise)
  );

  function automatic logic [1:0] adcsc_idx(input logic [31:0] a);
    return a[ADCSC_ADDR_MSB:ADCSC_ADDR_LSB];
  endfunction

  function automatic logic sim_active(input adcsc_ctrl_t c);
    return c.sim && !c.b12 && (c.chps != ADCSC_CHPS_ONE); // [RULE_09] [RULE_12]
  endfunction

  function automatic logic [31:0] ctrl_word(input adcsc_ctrl_t c);
    logic [31:0] w;
    w = '0;
    w[ADCSC_POS_DONE] = c.done;
    w[ADCSC_POS_SAMPLE_CONTROL] = c.sample_control;
    w[ADCSC_POS_AUTO_SAMPLE] = c.auto_sample;
    w[ADCSC_POS_SIM] = c.sim && !c.b12; // [RULE_12]
    w[ADCSC_POS_GRP] = c.grp;
    w[ADCSC_POS_SEL_HI:ADCSC_POS_SEL_LO] = c.sel;
    w[ADCSC_POS_CHPS_HI:ADCSC_POS_CHPS_LO] = c.chps;
    w[ADCSC_POS_B12] = c.b12;
    return w;
  endfunction

  logic [31:0] ctrl_rd;
  assign ctrl_rd = ctrl_word(st_q.ctrl);
  logic addr_ok;
  logic hw_trig;
  logic [1:0] nch;
  assign addr_ok = hsel && hready && htrans == ADCSC_HTRANS_NONSEQ;

  always_comb begin
    hw_trig = 1'b0;
    if (st_q.ctrl.grp) begin
      unique case (st_q.ctrl.sel)
        ADCSC_SEL_0: hw_trig = trig_rise.pwm1; // [RULE_01]
        ADCSC_SEL_1: hw_trig = trig_rise.pwm2; // [RULE_01]
        ADCSC_SEL_2: hw_trig = trig_rise.pwm3; // [RULE_01]
        default: hw_trig = 1'b0;
      endcase
    end else begin
      unique case (st_q.ctrl.sel)
        ADCSC_SEL_1: hw_trig = trig_rise.ext0; // [RULE_06]
        ADCSC_SEL_2: hw_trig = trig_rise.tmr3; // [RULE_04]
        ADCSC_SEL_3: hw_trig = trig_rise.pwm_sev; // [RULE_05]
        ADCSC_SEL_4: hw_trig = trig_rise.tmr5; // [RULE_04]
        ADCSC_SEL_6: hw_trig = trig_rise.charge_time_unit; // [RULE_03]
        ADCSC_SEL_7: hw_trig = st_q.cnt == st_q.sample_control_time; // [RULE_02]
        default: hw_trig = 1'b0;
      endcase
    end
  end

  assign nch = st_q.ctrl.chps[1] ? 2'h3 : st_q.ctrl.chps;

  always_comb begin
    logic manual;
    logic sw_clr_sample_control;
    logic sw_set_sample_control;
    logic start;
    logic [31:0] w;
    manual = 1'b0;
    sw_clr_sample_control = 1'b0;
    sw_set_sample_control = 1'b0;
    start = 1'b0;
    w = hwdata;
    st_d = st_q;
    st_d.ana.start = 1'b0;
    manual = !st_q.ctrl.grp && st_q.ctrl.sel == ADCSC_SEL_0;
    // Data phase of a write
    if (st_q.wr_pend) begin
      unique case (st_q.wr_idx)
        adcsc_idx(ADCSC_CTRL_ADDR): begin
          st_d.ctrl.auto_sample = w[ADCSC_POS_AUTO_SAMPLE];
          st_d.ctrl.sim = w[ADCSC_POS_SIM] && !w[ADCSC_POS_B12]; // [RULE_12]
          st_d.ctrl.grp = w[ADCSC_POS_GRP];
          st_d.ctrl.sel = w[ADCSC_POS_SEL_HI:ADCSC_POS_SEL_LO];
          st_d.ctrl.chps = w[ADCSC_POS_CHPS_HI:ADCSC_POS_CHPS_LO];
          st_d.ctrl.b12 = w[ADCSC_POS_B12];
          if (!w[ADCSC_POS_DONE]) begin
            st_d.ctrl.done = 1'b0; // [RULE_16] [RULE_17]
          end
          sw_set_sample_control = w[ADCSC_POS_SAMPLE_CONTROL] && !st_q.ctrl.sample_control;
          sw_clr_sample_control = !w[ADCSC_POS_SAMPLE_CONTROL] && st_q.ctrl.sample_control && manual; // [RULE_07]
        end
        adcsc_idx(ADCSC_SCAN_ADDR): st_d.scan = w[1:0]; // [RULE_20] [RULE_22]
        adcsc_idx(ADCSC_TIME_ADDR): st_d.sample_control_time = w[7:0];
        adcsc_idx(ADCSC_OPA_ADDR): st_d.opa = w[1:0];
      endcase
    end
    st_d.wr_pend = addr_ok && hwrite;
    st_d.wr_idx = adcsc_idx(haddr);
    if (addr_ok && !hwrite) begin
      unique case (adcsc_idx(haddr))
        adcsc_idx(ADCSC_CTRL_ADDR): st_d.rdata = ctrl_word(st_q.ctrl);
        adcsc_idx(ADCSC_SCAN_ADDR): st_d.rdata = {30'h0000_0000, st_q.scan};
        adcsc_idx(ADCSC_TIME_ADDR): st_d.rdata = {24'h00_0000, st_q.sample_control_time};
        adcsc_idx(ADCSC_OPA_ADDR): st_d.rdata = {30'h0000_0000, st_q.opa};
      endcase
    end
    // Sampling and conversion sequencer
    unique case (st_q.state)
      ADCSC_IDLE: begin
        if (sw_set_sample_control) begin
          st_d.ctrl.sample_control = 1'b1;
          st_d.state = ADCSC_SAMPLE;
          st_d.cnt = '0;
        end
      end
      ADCSC_SAMPLE: begin
        st_d.cnt = st_q.cnt + 8'h01;
        if (sw_clr_sample_control || (!manual && hw_trig)) begin
          start = 1'b1; // [RULE_08]
        end
      end
      ADCSC_CONVERT: begin
        st_d.cnt = st_q.cnt + 8'h01;
        if (st_q.cnt == ADCSC_CONV_TIME) begin
          st_d.cnt = '0;
          if (!sim_active(st_q.ctrl) && st_q.seq != nch) begin
            st_d.seq = st_q.seq + 2'h1; // [RULE_11]
            st_d.ana.start = 1'b1;
          end else begin
            st_d.ctrl.done = 1'b1; // [RULE_15]
            st_d.seq = '0;
            if (st_q.ctrl.auto_sample) begin
              st_d.ctrl.sample_control = 1'b1; // [RULE_13]
              st_d.state = ADCSC_SAMPLE;
            end else begin
              st_d.state = ADCSC_IDLE;
            end
          end
        end
      end
      default: st_d.state = ADCSC_IDLE;
    endcase
    if (start) begin
      st_d.ctrl.sample_control = 1'b0;
      st_d.ctrl.done = 1'b0; // [RULE_18]
      st_d.state = ADCSC_CONVERT;
      st_d.cnt = '0;
      st_d.seq = '0;
      st_d.ana.start = 1'b1;
    end
    st_d.ana.sample = st_d.ctrl.sample_control; // [RULE_14]
    st_d.ana.sim_en = sim_active(st_d.ctrl); // [RULE_10]
    st_d.ana.ch_mask = 4'h0;
    if (sim_active(st_d.ctrl)) begin
      st_d.ana.ch_mask = st_d.ctrl.chps[1] ? 4'hF : 4'h3; // [RULE_10]
    end else begin
      st_d.ana.ch_mask[st_d.seq] = 1'b1; // [RULE_11]
    end
    st_d.ana.scan_sel = st_d.scan; // [RULE_20]
    st_d.ana.use_opamp = st_d.scan & st_d.opa; // [RULE_21]
    st_d.ana.use_low_reference_voltage = st_d.scan & ~ADCSC_SCAN_PINS & ~st_d.opa; // [RULE_22]
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;
      st_q.sample_control_time <= ADCSC_SAMPLE_CONTROL_TIME_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign hrdata = st_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign analog_out = st_q.ana;

  sample_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    analog_out.sample == st_q.ctrl.sample_control) else $error("sample output differs from control"); // [RULE_14]
  done_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    analog_out.start && st_q.state == ADCSC_CONVERT && st_q.seq == 2'h0 |-> !st_q.ctrl.done)
    else $error("done not cleared at conversion start"); // [RULE_18]
  done_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(st_q.ctrl.done) |-> $past(st_q.state) == ADCSC_CONVERT) else $error("done set outside conversion"); // [RULE_15]
  sim_ignore_a: assert property (@(posedge hclk) disable iff (!hresetn)
    st_q.ctrl.chps == ADCSC_CHPS_ONE |-> !analog_out.sim_en) else $error("simultaneous active with one channel"); // [RULE_09]
  sim_b12_a: assert property (@(posedge hclk) disable iff (!hresetn)
    st_q.ctrl.b12 |-> !ctrl_rd[ADCSC_POS_SIM]) else $error("sim bit visible in 12-bit mode"); // [RULE_12]
  hw_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    st_q.state == ADCSC_SAMPLE && !(st_q.ctrl.grp == 1'b0 && st_q.ctrl.sel == ADCSC_SEL_0) && hw_trig
    |=> !st_q.ctrl.sample_control && st_q.state == ADCSC_CONVERT) else $error("trigger did not end sampling"); // [RULE_08]
  auto_restart_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(st_q.ctrl.done) && st_q.ctrl.auto_sample |-> st_q.ctrl.sample_control) else $error("auto-sample did not restart"); // [RULE_13]
  sim_four_a: assert property (@(posedge hclk) disable iff (!hresetn)
    analog_out.sim_en && st_q.ctrl.chps[1] |-> analog_out.ch_mask == 4'hF) else $error("four-channel mask wrong"); // [RULE_10]
  conv_cov: cover property (@(posedge hclk) disable iff (!hresetn) $rose(st_q.ctrl.done));
  auto_cov: cover property (@(posedge hclk) disable iff (!hresetn) st_q.ctrl.auto_sample && $rose(st_q.ctrl.sample_control));
  sim_cov: cover property (@(posedge hclk) disable iff (!hresetn) analog_out.sim_en && analog_out.start);
endmodule

/* File: tb/adcsc_analog_model.sv */
// Behavioural model of the analog sample-and-hold and conversion core.
// Assumes start is a one-cycle pulse per channel, or one for all channels when simultaneous, and sample is a level.
`timescale 1ns/1ns
module adcsc_analog_model
  import adcsc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire adcsc_analog_t analog_out,
  output int n_starts,
  output int n_bad
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      n_starts <= 0;
      n_bad <= 0;
    end else if (analog_out.start === 1'b1) begin
      n_starts <= n_starts + 1;
      // Amplifiers must be holding when a conversion starts
      if (analog_out.sample !== 1'b0) begin
        n_bad <= n_bad + 1;
      end
    end
  end
endmodule

/* File: tb/adcsc_tb_top.sv */
// Testbench for the sample and conversion control block.
// Assumes one AHB-Lite slave whose hreadyout is the bus hready.
`timescale 1ns/1ns
module adcsc_tb_top;
  import adcsc_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  adcsc_trig_t trig_in = '0;
  adcsc_analog_t analog_out;
  int n_starts;
  int n_bad;
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  int n0;
  logic [31:0] rd;
  logic [3:0] tg_code [9] = '{4'h8, 4'h9, 4'hA, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'hB};
  int tg_bit [9] = '{7, 6, 5, 0, 3, 4, 2, 1, -1};
  logic [1:0] ch_c [6] = '{2'h2, 2'h1, 2'h1, 2'h2, 2'h0, 2'h2};
  logic ch_s [6] = '{1, 1, 0, 0, 1, 1};
  logic ch_b [6] = '{0, 0, 0, 0, 0, 1};
  logic ch_e [6] = '{1, 1, 0, 0, 0, 0};
  int ch_n [6] = '{1, 1, 2, 4, 1, 4};
  always #5 hclk = ~hclk;
  adcsc_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .trig_in(trig_in), .analog_out(analog_out));
  adcsc_analog_model i_model (.hclk(hclk), .hresetn(hresetn), .analog_out(analog_out),
    .n_starts(n_starts), .n_bad(n_bad));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= ADCSC_HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= ADCSC_HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  function automatic logic [31:0] cv(logic g, logic [2:0] s, logic [1:0] c, logic sm, logic b, logic as,
                                     logic sp);
    return {21'h0, b, c, s, g, sm, as, sp, 1'b0};
  endfunction
  task automatic wait_starts(input int n);
    for (int k = 0; k < 300 && n_starts - n0 < n; k++) begin
      @(posedge hclk);
    end
  endtask
  task automatic wait_done;
    bus(1'b0, ADCSC_CTRL_ADDR, 32'h0);
    for (int k = 0; k < 60 && rd[0] !== 1'b1; k++) begin
      bus(1'b0, ADCSC_CTRL_ADDR, 32'h0);
    end
  endtask
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, ADCSC_CTRL_ADDR, 32'h0);
    chk(rd, 32'h0000_0000);
    bus(1'b0, ADCSC_TIME_ADDR, 32'h0);
    chk(rd, {24'h0, ADCSC_SAMPLE_CONTROL_TIME_RST});
    bus(1'b0, 32'h0000_0010, 32'h0);
    chk(rd, 32'h0000_0000);
    bus(1'b1, ADCSC_SCAN_ADDR, 32'h0000_0003);
    bus(1'b0, ADCSC_SCAN_ADDR, 32'h0);
    chk(rd, 32'h0000_0003);
    chk(analog_out.scan_sel, 2'b11);
    chk(analog_out.use_low_reference_voltage, 2'b10);
    bus(1'b1, ADCSC_OPA_ADDR, 32'h0000_0003);
    repeat (2) @(posedge hclk);
    chk(analog_out.use_opamp, 2'b11);
    $display("test registers ended");
    bus(1'b1, ADCSC_CTRL_ADDR, cv(0, 0, 0, 0, 0, 0, 1));
    repeat (2) @(posedge hclk);
    chk(analog_out.sample, 1'b1);
    n0 = n_starts;
    bus(1'b1, ADCSC_CTRL_ADDR, cv(0, 0, 0, 0, 0, 0, 0));
    wait_starts(1);
    chk(n_starts - n0, 1);
    bus(1'b0, ADCSC_CTRL_ADDR, 32'h0);
    chk(rd[0], 1'b0);
    wait_done();
    chk(rd[0], 1'b1);
    chk(analog_out.sample, 1'b0);
    bus(1'b1, ADCSC_CTRL_ADDR, 32'h0);
    bus(1'b0, ADCSC_CTRL_ADDR, 32'h0);
    chk(rd[0], 1'b0);
    bus(1'b1, ADCSC_CTRL_ADDR, 32'h0000_0001);
    bus(1'b0, ADCSC_CTRL_ADDR, 32'h0);
    chk(rd[0], 1'b0);
    $display("test manual ended");
    for (int i = 0; i < 9; i++) begin
      bus(1'b1, ADCSC_CTRL_ADDR, cv(tg_code[i][3], tg_code[i][2:0], 0, 0, 0, 0, 1));
      n0 = n_starts;
      // Edges on every other source must not end sampling
      trig_in <= (tg_bit[i] < 0) ? 8'hFF : ~(8'h01 << tg_bit[i]);
      repeat (10) @(posedge hclk);
      trig_in <= '0;
      repeat (10) @(posedge hclk);
      chk(n_starts - n0, 0);
      if (tg_bit[i] >= 0) begin
        trig_in <= 8'h01 << tg_bit[i];
        wait_starts(1);
        bus(1'b0, ADCSC_CTRL_ADDR, 32'h0);
        chk(rd[1:0], 2'b00);
        repeat (20) @(posedge hclk);
        trig_in <= '0;
      end else begin
        // Back to manual mode while still sampling, then end sampling by software
        bus(1'b1, ADCSC_CTRL_ADDR, cv(0, 0, 0, 0, 0, 0, 1));
        bus(1'b1, ADCSC_CTRL_ADDR, 32'h0);
      end
      wait_done();
      chk(n_starts - n0, 1);
    end
    $display("test triggers ended");
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, ADCSC_CTRL_ADDR, cv(0, 0, ch_c[i], ch_s[i], ch_b[i], 0, 1));
      bus(1'b0, ADCSC_CTRL_ADDR, 32'h0);
      chk(rd[3], ch_s[i] & ~ch_b[i]);
      chk(analog_out.sim_en, ch_e[i]);
      n0 = n_starts;
      bus(1'b1, ADCSC_CTRL_ADDR, cv(0, 0, ch_c[i], ch_s[i], ch_b[i], 0, 0));
      wait_done();
      chk(n_starts - n0, ch_n[i]);
    end
    $display("test channels ended");
    bus(1'b1, ADCSC_TIME_ADDR, 32'h0000_0005);
    n0 = n_starts;
    bus(1'b1, ADCSC_CTRL_ADDR, cv(0, 7, 0, 0, 0, 1, 1) | 32'h1);
    wait_starts(3);
    chk(n_starts - n0, 3);
    bus(1'b1, ADCSC_CTRL_ADDR, cv(0, 7, 0, 0, 0, 0, 1) | 32'h1);
    repeat (100) @(posedge hclk);
    chk(analog_out.sample, 1'b0);
    chk(n_bad, 0);
    $display("test auto ended");
    end_of_test();
  end
endmodule
